// file: dscc_defines.svh
`ifndef DSCC_DEFINES_SVH
`define DSCC_DEFINES_SVH

// ==========================================================
// register byte addresses (first and last byte of each word)
`define DSCC_ADR_START_LO 6'h04
`define DSCC_ADR_START_HI 6'h09
`define DSCC_ADR_HIGH_LO  6'h0a
`define DSCC_ADR_HIGH_HI  6'h0f
`define DSCC_ADR_DELTA_LO 6'h10
`define DSCC_ADR_DELTA_HI 6'h15
`define DSCC_ADR_UPD_LO   6'h16
`define DSCC_ADR_UPD_HI   6'h19
`define DSCC_ADR_RATE_LO  6'h1a
`define DSCC_ADR_RATE_HI  6'h1c
`define DSCC_ADR_CTRL     6'h1f

// ==========================================================
// mode codes held in the control byte
`define DSCC_MODE_TONE  3'h0
`define DSCC_MODE_FSK   3'h1
`define DSCC_MODE_RAMP  3'h2
`define DSCC_MODE_CHIRP 3'h3

// ==========================================================
// reset values and timing counts
`define DSCC_CTRL_RST   8'h01
`define DSCC_PINS_IDLE  18'h0000c
`define DSCC_UPD_HIGH   4'h8
`define DSCC_READ_NONE  8'h00

`endif

// file: dscc_pkg.sv
package dscc_pkg;

   // ==========================================================
   // control byte at the control address, msb first
   typedef struct packed {
      logic       both_accum_clear;  // hold both accumulators at zero
      logic       freq_accum_clear;  // one-shot clear of the sweep accumulator
      logic       triangle;          // automatic up/down sweep
      logic       spare;             // stored, no effect
      logic [2:0] mode;              // operating mode code
      logic       int_update;        // internal update timer selected
   } dscc_ctrl_t;

   // ==========================================================
   // host pins after synchronisation, one bundle
   typedef struct packed {
      logic [5:0] addr;              // register byte address
      logic [7:0] data;              // write data
      logic       wr_n;              // write strobe, low active
      logic       rd_n;              // read strobe, low active
      logic       key;               // keying / hold pin
      logic       upd;               // external update pin
   } dscc_pins_t;

   // ==========================================================
   // whole state of the sweep block
   typedef struct packed {
      logic        wr_q;             // previous write strobe level
      logic        upd_q;            // previous update pin level
      logic        key_q;            // previous keying pin level
      logic        tri_q;            // previous active triangle bit
      logic [47:0] b_start;          // buffered start tuning word
      logic [47:0] b_high;           // buffered second tuning word
      logic [47:0] b_delta;          // buffered delta step word
      logic [31:0] b_upd;            // update timer period
      logic [19:0] b_rate;           // buffered step interval count
      dscc_ctrl_t  b_ctrl;           // buffered control byte
      logic [47:0] a_start;          // active start tuning word
      logic [47:0] a_high;           // active second tuning word
      logic [47:0] a_delta;          // active delta step word
      logic [19:0] a_rate;           // active step interval count
      dscc_ctrl_t  a_ctrl;           // active control byte
      logic [47:0] freq_accumulator; // sweep offset
      logic [47:0] phase_accumulator;// phase of the synthesised tone
      logic [47:0] freq;             // frequency word fed to phase
      logic [19:0] rcnt;             // step interval down-counter
      logic        run;              // step counter running
      logic        dir_up;           // sweep heading upward
      logic [31:0] tcnt;             // update timer down-counter
      logic        half;             // half-rate enable for the timer
      logic [3:0]  uhi;              // update pin high time left
      logic        upd_out;          // update pin level driven out
      logic [7:0]  rdata;            // read data byte
      logic        rd_act;           // read strobe seen
      logic        pulse;            // step pulse this cycle
   } dscc_state_t;

endpackage

// file: dscc_sync.sv
`timescale 1ns/1ps

// ==========================================================
// two-stage synchroniser for a bundle of pins
module dscc_sync #(
   parameter int         W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);

   // both stages in one state word; stage one feeds only stage two
   typedef struct packed {
      logic [W-1:0] s1;   // first stage, metastable
      logic [W-1:0] s2;   // second stage, safe to read
   } dscc_sync_t;

   dscc_sync_t s_r;       // registered stages
   dscc_sync_t s_nxt;     // next stages

   // shift the pins through
   always_comb
   begin
      s_nxt    = s_r;
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end

   // idle pin levels at reset so no false strobe edge follows release
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_r.s1 <= RST;
         s_r.s2 <= RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.s2;

endmodule

// file: dscc_sweep.sv
// What this block does
// - mode 010 ramps between two tuning words
// - step counter gives N+1 clock period
// - triangle bit sweeps continuously, ignores pin changes
// - buffers reach core only on update edge
// - triangle start frequency follows pin level
// - new step and rate apply mid-ramp
// - ramp bounded by words, chirp unbounded
// - frequency clear bit fires one-clock clear
// - held clear bit refires each update
// - clearing keeps the delta step word
// - combined clear holds both accumulators zero
// - registers writable during combined clear
// - mode 011 is chirp from start word
// - step word msb sets chirp direction
// - chirp free between dc and half clock
// - hold pin freezes chirp step counter
// - held counter finishes old count first
// - update timer runs at half the system clock
// - chirp sweeps forever without destination
`timescale 1ns/1ps
`include "dscc_defines.svh"

module dscc_sweep (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [5:0]   bus_addr,
   input  wire logic [7:0]   bus_data_i,
   output logic [7:0]        bus_data_o,
   output logic              bus_data_oe_n,
   input  wire logic         bus_wr_n,
   input  wire logic         bus_rd_n,
   input  wire logic         key_hold,
   input  wire logic         upd_i,
   output logic              upd_o,
   output logic              upd_oe_n,
   output logic [47:0]       freq_word_o,
   output logic [47:0]       phase_o,
   output logic              ramp_pulse_o
);

   // ==========================================================
   // declarations
   dscc_pkg::dscc_state_t s;          // registered state
   dscc_pkg::dscc_state_t n;          // next state
   dscc_pkg::dscc_pins_t  pins_raw;   // pins before the synchroniser
   dscc_pkg::dscc_pins_t  pins;       // pins after the synchroniser
   logic                  wr_rise;    // end of a write strobe
   logic                  tz;         // update timer reached zero
   logic                  upd_evt;    // update event, one cycle
   logic                  hold;       // chirp frozen by the pin
   logic                  clr_pulse;  // one-shot accumulator clear
   logic                  tri_rise;   // triangle bit just went high
   logic                  pin_chg;    // keying pin changed level
   logic                  rpulse;     // step pulse
   logic [47:0]           span;       // distance between tuning words
   logic [48:0]           sum49;      // accumulator plus step, with carry
   logic [47:0]           tri_start;  // accumulator value at triangle start
   logic [47:0]           sum_word;   // start word plus accumulator
   logic [47:0]           tmp48;      // scratch for narrow registers
   logic [2:0]            mode;       // active mode code

   // ==========================================================
   // byte helpers; the lowest address holds the most significant byte
   function automatic logic in_rng(input logic [5:0] a, input logic [5:0] lo, input logic [5:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [47:0] put_byte(input logic [47:0] w, input logic [5:0] hi,
                                            input logic [5:0] a, input logic [7:0] d);
      logic [2:0] pos;
      pos = 3'(hi - a);
      put_byte = w;
      put_byte[{pos, 3'b000} +: 8] = d;
   endfunction

   function automatic logic [7:0] get_byte(input logic [47:0] w, input logic [5:0] hi, input logic [5:0] a);
      logic [2:0] pos;
      pos = 3'(hi - a);
      get_byte = w[{pos, 3'b000} +: 8];
   endfunction

   // read mux over the buffer side; unmapped bytes read as zero
   function automatic logic [7:0] read_byte(input dscc_pkg::dscc_state_t st, input logic [5:0] a);
      read_byte = `DSCC_READ_NONE;
      if (in_rng(a, `DSCC_ADR_START_LO, `DSCC_ADR_START_HI))
         read_byte = get_byte(st.b_start, `DSCC_ADR_START_HI, a);
      else if (in_rng(a, `DSCC_ADR_HIGH_LO, `DSCC_ADR_HIGH_HI))
         read_byte = get_byte(st.b_high, `DSCC_ADR_HIGH_HI, a);
      else if (in_rng(a, `DSCC_ADR_DELTA_LO, `DSCC_ADR_DELTA_HI))
         read_byte = get_byte(st.b_delta, `DSCC_ADR_DELTA_HI, a);
      else if (in_rng(a, `DSCC_ADR_UPD_LO, `DSCC_ADR_UPD_HI))
         read_byte = get_byte({16'h0000, st.b_upd}, `DSCC_ADR_UPD_HI, a);
      else if (in_rng(a, `DSCC_ADR_RATE_LO, `DSCC_ADR_RATE_HI))
         read_byte = get_byte({28'h0000000, st.b_rate}, `DSCC_ADR_RATE_HI, a);
      else if (a == `DSCC_ADR_CTRL)
         read_byte = st.b_ctrl;
   endfunction

   // ==========================================================
   // pin synchroniser; the host pins are asynchronous to mclk
   assign pins_raw = '{addr: bus_addr, data: bus_data_i, wr_n: bus_wr_n,
                       rd_n: bus_rd_n, key: key_hold, upd: upd_i};

   dscc_sync #(
      .W   ($bits(dscc_pkg::dscc_pins_t)),
      .RST (`DSCC_PINS_IDLE)
   ) u_sync (
      .mclk (mclk),
      .rst  (rst),
      .d    (pins_raw),
      .q    (pins)
   );

   // ==========================================================
   // next-state logic
   always_comb
   begin
      n     = s;
      tmp48 = '0;
      mode  = s.a_ctrl.mode;

      // register port: a write lands when the strobe rises again
      wr_rise  = pins.wr_n & ~s.wr_q;
      n.wr_q   = pins.wr_n;
      if (wr_rise)
      begin
         // writes go to buffers only, also during a combined clear
         if (in_rng(pins.addr, `DSCC_ADR_START_LO, `DSCC_ADR_START_HI))
            n.b_start = put_byte(s.b_start, `DSCC_ADR_START_HI, pins.addr, pins.data);
         else if (in_rng(pins.addr, `DSCC_ADR_HIGH_LO, `DSCC_ADR_HIGH_HI))
            n.b_high = put_byte(s.b_high, `DSCC_ADR_HIGH_HI, pins.addr, pins.data);
         else if (in_rng(pins.addr, `DSCC_ADR_DELTA_LO, `DSCC_ADR_DELTA_HI))
            n.b_delta = put_byte(s.b_delta, `DSCC_ADR_DELTA_HI, pins.addr, pins.data);
         else if (in_rng(pins.addr, `DSCC_ADR_UPD_LO, `DSCC_ADR_UPD_HI))
         begin
            tmp48   = put_byte({16'h0000, s.b_upd}, `DSCC_ADR_UPD_HI, pins.addr, pins.data);
            n.b_upd = tmp48[31:0];
         end
         else if (in_rng(pins.addr, `DSCC_ADR_RATE_LO, `DSCC_ADR_RATE_HI))
         begin
            tmp48    = put_byte({28'h0000000, s.b_rate}, `DSCC_ADR_RATE_HI, pins.addr, pins.data);
            n.b_rate = tmp48[19:0];
         end
         else if (pins.addr == `DSCC_ADR_CTRL)
            n.b_ctrl = pins.data;
      end
      n.rd_act = ~pins.rd_n;
      n.rdata  = read_byte(s, pins.addr);

      // update timer: counts at half rate; period read from the buffer
      // so the timer can start before any update has happened
      n.half = ~s.half;
      tz     = s.a_ctrl.int_update & s.half & (s.tcnt == 32'h00000000);
      if (s.a_ctrl.int_update & s.half)
         n.tcnt = tz ? s.b_upd : s.tcnt - 32'h00000001;
      upd_evt = s.a_ctrl.int_update ? tz : (pins.upd & ~s.upd_q);
      n.upd_q = pins.upd;
      // fixed high time on the update pin after each internal event
      if (tz)
         n.uhi = `DSCC_UPD_HIGH;
      else if (s.uhi != 4'h0)
         n.uhi = s.uhi - 4'h1;
      n.upd_out = (n.uhi != 4'h0);

      // sweep helpers
      hold      = (mode == `DSCC_MODE_CHIRP) & pins.key;
      clr_pulse = upd_evt & s.b_ctrl.freq_accum_clear;
      span      = s.a_high - s.a_start;
      tri_rise  = (mode == `DSCC_MODE_RAMP) & s.a_ctrl.triangle & ~s.tri_q;
      tri_start = pins.key ? span : 48'h000000000000;
      n.tri_q   = s.a_ctrl.triangle;
      pin_chg   = pins.key ^ s.key_q;
      n.key_q   = pins.key;
      rpulse    = s.run & ~hold & (s.rcnt == 20'h00000);
      n.pulse   = rpulse;
      sum49     = {1'b0, s.freq_accumulator} + {1'b0, s.a_delta};
      sum_word  = s.a_start + s.freq_accumulator;

      // step counter; held at its count while the chirp is frozen
      if (s.run & ~hold)
         n.rcnt = rpulse ? s.a_rate : s.rcnt - 20'h00001;

      unique case (mode)
         `DSCC_MODE_RAMP:
         begin
            if (tri_rise)
            begin
               // start at the low word with the pin low, else at the high
               n.dir_up           = ~pins.key;
               n.freq_accumulator = tri_start;
               n.run              = 1'b1;
            end
            else
            begin
               if (rpulse)
               begin
                  if (s.dir_up)
                  begin
                     // clamp at the high word; a step never overshoots
                     if (sum49 >= {1'b0, span})
                     begin
                        n.freq_accumulator = span;
                        if (s.a_ctrl.triangle)
                           n.dir_up = 1'b0;
                        else
                           n.run = 1'b0;
                     end
                     else
                        n.freq_accumulator = sum49[47:0];
                  end
                  else
                  begin
                     // clamp at the low word
                     if (s.freq_accumulator <= s.a_delta)
                     begin
                        n.freq_accumulator = 48'h000000000000;
                        if (s.a_ctrl.triangle)
                           n.dir_up = 1'b1;
                        else
                           n.run = 1'b0;
                     end
                     else
                        n.freq_accumulator = s.freq_accumulator - s.a_delta;
                  end
               end
               // a pin change restarts or reverses the ramp, unless triangle
               if (~s.a_ctrl.triangle & pin_chg)
               begin
                  n.dir_up = pins.key;
                  n.run    = 1'b1;
               end
            end
         end
         `DSCC_MODE_CHIRP:
         begin
            // no destination: add the signed step and let it wrap
            n.run = 1'b1;
            if (rpulse)
               n.freq_accumulator = s.freq_accumulator + s.a_delta;
         end
         default:
         begin
            n.run = 1'b0;
         end
      endcase

      // one-shot clear back to the start point; step word is left alone
      if (clr_pulse)
      begin
         n.freq_accumulator = ((mode == `DSCC_MODE_RAMP) & ~s.dir_up) ? span : 48'h000000000000;
         if (mode == `DSCC_MODE_RAMP)
            n.run = 1'b1;
      end

      // buffers move into the core; rates apply at once unless frozen
      if (upd_evt)
      begin
         n.a_start = s.b_start;
         n.a_high  = s.b_high;
         n.a_delta = s.b_delta;
         n.a_rate  = s.b_rate;
         n.a_ctrl  = s.b_ctrl;
         if (~hold)
            n.rcnt = s.b_rate;
      end

      // combined clear wins over everything; output sits at 0 Hz
      if (s.a_ctrl.both_accum_clear)
      begin
         n.freq_accumulator  = 48'h000000000000;
         n.phase_accumulator = 48'h000000000000;
      end
      else
         n.phase_accumulator = s.phase_accumulator + s.freq;

      // frequency word fed to the phase accumulator
      if (s.a_ctrl.both_accum_clear)
         n.freq = 48'h000000000000;
      else if (mode == `DSCC_MODE_FSK)
         n.freq = pins.key ? s.a_high : s.a_start;
      else if ((mode == `DSCC_MODE_RAMP) || (mode == `DSCC_MODE_CHIRP))
         n.freq = sum_word;
      else
         n.freq = s.a_start;
   end

   // ==========================================================
   // state register; control defaults to internal update
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s        <= '0;
         s.wr_q   <= 1'b1;
         s.b_ctrl <= `DSCC_CTRL_RST;
         s.a_ctrl <= `DSCC_CTRL_RST;
      end
      else
      begin
         s <= n;
      end
   end

   // ==========================================================
   // outputs; the data bus is driven only while a read is seen
   assign bus_data_o    = s.rdata;
   assign bus_data_oe_n = ~s.rd_act;
   assign upd_o         = s.upd_out;
   assign upd_oe_n      = ~s.a_ctrl.int_update;
   assign freq_word_o   = s.freq;
   assign phase_o       = s.phase_accumulator;
   assign ramp_pulse_o  = s.pulse;

   // ==========================================================
   // assertions
   AST_FREQ_SUM: assert property (@(posedge mclk) disable iff (rst)
      (((mode == `DSCC_MODE_RAMP) || (mode == `DSCC_MODE_CHIRP)) && !s.a_ctrl.both_accum_clear)
      |=> (s.freq == $past(sum_word)))
      else $error("frequency word is not start word plus accumulator");

   AST_STEP_RELOAD: assert property (@(posedge mclk) disable iff (rst)
      (rpulse && !upd_evt) |=> (s.rcnt == $past(s.a_rate)) && s.pulse)
      else $error("step counter did not reload after its pulse");

   AST_UPD_RATE: assert property (@(posedge mclk) disable iff (rst)
      (upd_evt && !hold) |=> (s.rcnt == $past(s.b_rate)) && (s.a_delta == $past(s.b_delta)))
      else $error("new step or rate not applied at update");

   AST_BOTH_CLEAR: assert property (@(posedge mclk) disable iff (rst)
      s.a_ctrl.both_accum_clear |=> (s.freq_accumulator == '0) && (s.phase_accumulator == '0) && (s.freq == '0))
      else $error("combined clear did not hold accumulators at zero");

   AST_TRI_START: assert property (@(posedge mclk) disable iff (rst)
      (tri_rise && !clr_pulse && !s.a_ctrl.both_accum_clear)
      |=> (s.freq_accumulator == $past(tri_start)) && (s.dir_up == !$past(pins.key)))
      else $error("triangle sweep started at the wrong word");

   AST_HOLD_FREEZE: assert property (@(posedge mclk) disable iff (rst)
      (hold && !clr_pulse && !s.a_ctrl.both_accum_clear)
      |=> $stable(s.freq_accumulator) && $stable(s.rcnt))
      else $error("chirp moved while hold was high");

   AST_CLR_ONESHOT: assert property (@(posedge mclk) disable iff (rst)
      (clr_pulse && (mode == `DSCC_MODE_CHIRP) && !s.a_ctrl.both_accum_clear)
      |=> (s.freq_accumulator == '0) && (s.a_delta == $past(s.b_delta)))
      else $error("frequency clear one-shot missing or step word lost");

   AST_CHIRP_STEP: assert property (@(posedge mclk) disable iff (rst)
      (rpulse && (mode == `DSCC_MODE_CHIRP) && !clr_pulse && !s.a_ctrl.both_accum_clear)
      |=> (s.freq_accumulator == $past(sum49[47:0])))
      else $error("chirp step not added in the signed direction");

   AST_RAMP_STOP: assert property (@(posedge mclk) disable iff (rst)
      (rpulse && (mode == `DSCC_MODE_RAMP) && s.dir_up && !s.a_ctrl.triangle && (sum49 >= {1'b0, span})
       && !pin_chg && !clr_pulse && !tri_rise && !s.a_ctrl.both_accum_clear)
      |=> !s.run && (s.freq_accumulator == $past(span)))
      else $error("ramp did not stop at the high word");

   AST_UPD_HIGH: assert property (@(posedge mclk) disable iff (rst)
      tz |=> s.upd_out [*8])
      else $error("update pin high time too short");

endmodule

// file: dscc_host.sv
`timescale 1ns/1ps
// ==========================================================
// host controller model: byte writes, update pin and keying pin
module dscc_host (
   input  wire logic  mclk,
   input  wire logic [7:0] bus_data_o,
   input  wire logic  bus_data_oe_n,
   output logic [5:0] bus_addr,
   output logic [7:0] bus_data_i,
   output logic       bus_wr_n,
   output logic       bus_rd_n,
   output logic       key_hold,
   output logic       upd_h
);
   initial
   begin
      bus_addr = 6'h00;
      bus_data_i = 8'h00;
      bus_wr_n = 1'b1;
      bus_rd_n = 1'b1;
      key_hold = 1'b0;
      upd_h = 1'b0;
   end
   // ==========================================================
   // one byte write, both strobe phases four clocks for the synchroniser
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge mclk);
      bus_addr = a;
      bus_data_i = d;
      bus_wr_n = 1'b0;
      repeat (4) @(negedge mclk);
      bus_wr_n = 1'b1;
      repeat (4) @(negedge mclk);
      // hold time is over, so the lines no longer show the byte
      bus_addr = ~a;
      bus_data_i = ~d;
   endtask
   // one byte read; data and enable taken while the strobe still stands
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic oe_n);
      @(negedge mclk);
      bus_addr = a;
      bus_rd_n = 1'b0;
      repeat (5) @(negedge mclk);
      d = bus_data_o;
      oe_n = bus_data_oe_n;
      bus_rd_n = 1'b1;
      repeat (4) @(negedge mclk);
   endtask
   // lowest address carries the most significant byte
   task automatic wr_word(input logic [5:0] a, input logic [47:0] v, input int n);
      for (int i = 0; i < n; i++)
         wr(a + 6'(i), v[8*(n-1-i) +: 8]);
   endtask
   // rising edge on the update pin moves buffers into the core
   task automatic update;
      @(negedge mclk);
      upd_h = 1'b1;
      repeat (4) @(negedge mclk);
      upd_h = 1'b0;
      repeat (4) @(negedge mclk);
   endtask
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [5:0]  bus_addr;
   logic [7:0]  bus_data_i;
   logic        bus_wr_n, key_hold, upd_h, upd_o, upd_oe_n, ramp_pulse_o;
   logic        bus_rd_n, bus_data_oe_n, rb_oe;
   logic [7:0]  bus_data_o, rb;
   logic [47:0] freq_word_o, phase_o, prev, s, d, step_q[$];
   int          errors = 0, n_tests = 0, gap = 0, rate = 0;
   bit          armed = 1'b0;
   // shared update wire: the block drives it only while its enable is low
   wire logic   upd_i = upd_oe_n ? upd_h : upd_o;
   always #5 mclk = ~mclk;
   dscc_host i_dscc_host (.mclk(mclk), .bus_data_o(bus_data_o), .bus_data_oe_n(bus_data_oe_n),
      .bus_addr(bus_addr), .bus_data_i(bus_data_i), .bus_wr_n(bus_wr_n), .bus_rd_n(bus_rd_n),
      .key_hold(key_hold), .upd_h(upd_h));
   dscc_sweep i_dscc_sweep (.mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_data_i(bus_data_i),
      .bus_data_o(bus_data_o), .bus_data_oe_n(bus_data_oe_n), .bus_wr_n(bus_wr_n), .bus_rd_n(bus_rd_n),
      .key_hold(key_hold),
      .upd_i(upd_i), .upd_o(upd_o), .upd_oe_n(upd_oe_n), .freq_word_o(freq_word_o),
      .phase_o(phase_o), .ramp_pulse_o(ramp_pulse_o));
   // ==========================================================
   // comparison, verdict and watchdog
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #300us;
      errors++;
      summarize;
   end
   // ==========================================================
   // monitor: each step pulse after the first takes the oldest noted step off the queue
   always @(posedge mclk)
   begin
      if (ramp_pulse_o === 1'b1)
      begin
         if (armed && step_q.size() > 0)
         begin
            check("step size", freq_word_o - prev, step_q.pop_front());
            check("step gap", 48'(gap), 48'(rate + 1));
         end
         armed = 1'b1;
         prev = freq_word_o;
         gap = 1;
      end
      else
         gap++;
   end
   // ==========================================================
   // main sequence
   initial
   begin
      void'($urandom(32'h51aa));
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      // ramped keying between two words eight steps apart
      rate = 3;
      i_dscc_host.wr_word(6'h04, 48'h1000, 6);
      i_dscc_host.wr_word(6'h0a, 48'h1080, 6);
      i_dscc_host.wr_word(6'h10, 48'h10, 6);
      i_dscc_host.wr_word(6'h1a, 48'(rate), 3);
      i_dscc_host.rd(6'h08, rb, rb_oe);
      check("read start byte", 48'(rb), 48'h10);
      check("read enable", 48'(rb_oe), 48'h0);
      i_dscc_host.wr(6'h1f, 8'h04);
      i_dscc_host.update;
      repeat (20) @(negedge mclk);
      check("ramp idle", freq_word_o, 48'h1000);
      armed = 1'b0;
      repeat (4) step_q.push_back(48'h10);
      key_hold = 1'b1;
      repeat (100) @(negedge mclk);
      check("ramp top", freq_word_o, 48'h1080);
      key_hold = 1'b0;
      repeat (100) @(negedge mclk);
      check("ramp bottom", freq_word_o, 48'h1000);
      // triangle with the pin low starts at the low word heading up
      i_dscc_host.wr(6'h1f, 8'h24);
      i_dscc_host.update;
      armed = 1'b0;
      repeat (4) step_q.push_back(48'h10);
      for (int i = 0; i < 100 && step_q.size() > 0; i++)
         @(negedge mclk);
      check("triangle steps", 48'(step_q.size()), 48'h0);
      // chirp with random step and rate, changed once while running
      s = {8'h00, 32'($urandom), 8'h00};
      i_dscc_host.wr_word(6'h04, s, 6);
      i_dscc_host.wr(6'h1f, 8'h06);
      for (int k = 0; k < 2; k++)
      begin
         d = {16'($urandom), 32'($urandom)};
         rate = 2 + $urandom % 4;
         i_dscc_host.wr_word(6'h10, d, 6);
         i_dscc_host.wr_word(6'h1a, 48'(rate), 3);
         i_dscc_host.update;
         armed = 1'b0;
         repeat (5) step_q.push_back(d);
         for (int i = 0; i < 400 && step_q.size() > 0; i++)
            @(negedge mclk);
         check("steps seen", 48'(step_q.size()), 48'h0);
      end
      // hold pin freezes the chirp
      key_hold = 1'b1;
      repeat (10) @(negedge mclk);
      prev = freq_word_o;
      repeat (50) @(negedge mclk);
      check("held freq", freq_word_o, prev);
      // the host could ramp its amplitude down here; no amplitude path in this block
      key_hold = 1'b0;
      // frequency clear one-shot plus combined clear, reprogrammed while cleared
      i_dscc_host.wr(6'h1f, 8'hc6);
      i_dscc_host.update;
      repeat (10) @(negedge mclk);
      check("cleared freq", freq_word_o, 48'h0);
      check("cleared phase", phase_o, 48'h0);
      s = {8'h00, 32'($urandom), 8'h00};
      i_dscc_host.wr_word(6'h04, s, 6);
      i_dscc_host.wr_word(6'h10, 48'h0, 6);
      i_dscc_host.wr(6'h1f, 8'h06);
      i_dscc_host.update;
      repeat (10) @(negedge mclk);
      check("new start", freq_word_o, s);
      summarize;
   end
endmodule
